// file: rsl_pkg.sv
// Shared constants for the radio serial link
package rsl_pkg;
    localparam int unsigned CLK_MHZ = 20;
    localparam int unsigned LINK_MAX_MHZ = 10;
    // Half period of the link clock in system cycles; three keeps the link well under
    // the limit and lets the radio's four-cycle MISO lag settle before sampling
    localparam int unsigned HALF_CYC = 3;
    localparam logic [3:0] HALF_LAST = 4'(HALF_CYC - 1);
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NREGS = 128;
    localparam logic [7:0] RADIO_REG_RESET = 8'h00;
    // Control register fields
    localparam int unsigned CTL_ENABLE = 0;
    localparam int unsigned CTL_MASTER = 1;
    localparam int unsigned CTL_PHASE = 2;
    localparam int unsigned CTL_POLAR = 3;
    localparam int unsigned CTL_SELECT = 4;
    localparam int unsigned CTL_IRQEN = 5;
    localparam int unsigned CTL_DONE = 6;
    localparam int unsigned CTL_WCOL = 7;
    localparam logic [7:0] CTL_RESET = 8'h10;
    // Register select on the core-side command port
    localparam logic REG_CTL = 1'b0;
    localparam logic REG_DATA = 1'b1;
endpackage

// file: rsl_if.sv
// Link between core-side master and radio-side slave
`timescale 1ns/1ps
`default_nettype none
interface rsl_if;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic nsel;
    modport master (output sck, output mosi, output nsel, input miso, input miso_oe);
    modport slave (input sck, input mosi, input nsel, output miso, output miso_oe);
endinterface
`default_nettype wire

// file: rsl_master.sv
// Core-side serial master engine for the radio link
`timescale 1ns/1ps
`default_nettype none
module rsl_master
    import rsl_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic REG_SEL,
    input wire logic [7:0] WDATA,
    output logic [7:0] RDATA,
    output logic IRQ,
    output logic BUSY,
    rsl_if.master link
);
    import rsl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} rsl_state_t;
    rsl_state_t state_r, state_nxt;
    logic [7:0] ctl_r;
    logic [7:0] txbuf_r;
    logic txfull_r;
    logic [7:0] shift_r;
    logic [7:0] rxbuf_r;
    logic [3:0] tick_r;
    logic [2:0] bit_r;
    logic sck_r, mosi_r;
    logic [7:0] rdata_r;
    logic irq_r;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic enabled = ctl_r[CTL_ENABLE] & ctl_r[CTL_MASTER];
    wire logic wr_ctl = WR_EN & (REG_SEL == REG_CTL);
    wire logic wr_dat = WR_EN & (REG_SEL == REG_DATA);
    wire logic collide = wr_dat & txfull_r;
    wire logic half_end = (tick_r == HALF_LAST);
    wire logic start = (state_r == ST_IDLE) & txfull_r & enabled;
    wire logic byte_end = (state_r == ST_HIGH) & half_end & (bit_r == BIT_LAST);
    // Disabled engine sees MISO as zero, as a floating pin would be unused
    wire logic miso_in = enabled & link.miso;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: if (start) state_nxt = ST_LOW;
            ST_LOW: if (half_end) state_nxt = ST_HIGH;
            ST_HIGH: if (half_end) state_nxt = (bit_r == BIT_LAST) ? ST_IDLE : ST_LOW;
        endcase
        if (!enabled) state_nxt = ST_IDLE;
    end

    // ------------------------------------------------------------
    // Engine
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= ST_IDLE;
            tick_r <= 4'h0;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tick_r <= (state_r == ST_IDLE || half_end) ? 4'h0 : tick_r + 4'h1;
            // Idle-low clock, data valid on the first (rising) edge
            sck_r <= (state_nxt == ST_HIGH);
            if (start) begin
                shift_r <= txbuf_r;
                bit_r <= 3'h0;
                mosi_r <= txbuf_r[7];
            end else if (state_r == ST_HIGH && half_end) begin
                // Sampled at the end of the high half: the radio's synchronised
                // MISO trails the falling edge by four cycles
                shift_r <= {shift_r[6:0], miso_in};
                mosi_r <= shift_r[6];
                bit_r <= bit_r + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ctl_r <= CTL_RESET;
            txbuf_r <= 8'h00;
            txfull_r <= 1'b0;
            rxbuf_r <= 8'h00;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            if (wr_ctl) begin
                ctl_r[5:0] <= WDATA[5:0];
                // Flags clear by writing zero; a same-cycle set still wins
                ctl_r[CTL_DONE] <= (WDATA[CTL_DONE] & ctl_r[CTL_DONE]) | byte_end;
                ctl_r[CTL_WCOL] <= (WDATA[CTL_WCOL] & ctl_r[CTL_WCOL]) | collide;
            end else begin
                if (byte_end) ctl_r[CTL_DONE] <= 1'b1;
                if (collide) ctl_r[CTL_WCOL] <= 1'b1;
            end
            if (wr_dat && !txfull_r) begin
                txbuf_r <= WDATA;
                txfull_r <= 1'b1;
            end else if (start) begin
                txfull_r <= 1'b0;
            end
            if (byte_end) rxbuf_r <= {shift_r[6:0], miso_in};
            if (RD_EN) rdata_r <= (REG_SEL == REG_DATA) ? rxbuf_r : ctl_r;
            irq_r <= ctl_r[CTL_IRQEN] & (ctl_r[CTL_DONE] | ctl_r[CTL_WCOL]);
        end
    end

    assign RDATA = rdata_r;
    assign IRQ = irq_r;
    assign BUSY = (state_r != ST_IDLE);
    assign link.sck = sck_r;
    assign link.mosi = mosi_r;
    assign link.nsel = ctl_r[CTL_SELECT];
endmodule // rsl_master
`default_nettype wire

// file: rsl_radio.sv
// Radio-side serial slave with 128 control registers
`timescale 1ns/1ps
`default_nettype none
module rsl_radio
    import rsl_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [6:0] PEEK_ADDR,
    output logic [7:0] PEEK_DATA,
    output logic WR_STB,
    rsl_if.slave link
);
    import rsl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers, three stages
    // ------------------------------------------------------------
    logic [2:0] sck_s_r, mosi_s_r, nsel_s_r;
    logic sck_r, mosi_r, nsel_r;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sck_s_r <= 3'h0;
            mosi_s_r <= 3'h0;
            nsel_s_r <= 3'h7;
            sck_r <= 1'b0;
            mosi_r <= 1'b0;
            nsel_r <= 1'b1;
        end else begin
            sck_s_r <= {sck_s_r[1:0], link.sck};
            mosi_s_r <= {mosi_s_r[1:0], link.mosi};
            nsel_s_r <= {nsel_s_r[1:0], link.nsel};
            if (sck_s_r[1] == sck_s_r[2]) sck_r <= sck_s_r[2];
            if (mosi_s_r[1] == mosi_s_r[2]) mosi_r <= mosi_s_r[2];
            if (nsel_s_r[1] == nsel_s_r[2]) nsel_r <= nsel_s_r[2];
        end
    end
    wire logic sck_new = (sck_s_r[1] == sck_s_r[2]) ? sck_s_r[2] : sck_r;
    wire logic rise = sck_new & ~sck_r & ~nsel_r;
    wire logic fall = ~sck_new & sck_r & ~nsel_r;
    wire logic mosi_now = (mosi_s_r[1] == mosi_s_r[2]) ? mosi_s_r[2] : mosi_r;

    // ------------------------------------------------------------
    // Transaction decode
    // ------------------------------------------------------------
    logic [7:0] regs_r [NREGS];
    logic [7:0] sh_r, out_r;
    logic [2:0] cnt_r;
    logic have_addr_r, write_r, miso_r, wstb_r;
    logic [6:0] addr_r;
    wire logic [7:0] sh_in = {sh_r[6:0], mosi_now};
    wire logic byte_done = rise & (cnt_r == BIT_LAST);

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sh_r <= 8'h00;
            out_r <= 8'h00;
            cnt_r <= 3'h0;
            have_addr_r <= 1'b0;
            write_r <= 1'b0;
            addr_r <= 7'h00;
            miso_r <= 1'b0;
            wstb_r <= 1'b0;
        end else begin
            wstb_r <= 1'b0;
            if (nsel_r) begin
                cnt_r <= 3'h0;
                have_addr_r <= 1'b0;
            end else if (rise) begin
                sh_r <= sh_in;
                cnt_r <= cnt_r + 3'h1;
                if (byte_done && !have_addr_r) begin
                    write_r <= sh_in[7];
                    addr_r <= sh_in[6:0];
                    out_r <= regs_r[sh_in[6:0]];
                    have_addr_r <= 1'b1;
                end else if (byte_done) begin
                    // Next register follows without a new address
                    addr_r <= addr_r + 7'h01;
                    out_r <= regs_r[7'(addr_r + 7'h01)];
                    wstb_r <= write_r;
                end
            end else if (fall && have_addr_r && !write_r) begin
                miso_r <= out_r[7];
                out_r <= {out_r[6:0], out_r[7]};
            end
        end
    end

    // Registers written in a write transaction; reads leave them alone
    genvar gi;
    generate
        for (gi = 0; gi < NREGS; gi++) begin : g_reg
            always_ff @(posedge MCLK or negedge NRST) begin
                if (!NRST) regs_r[gi] <= RADIO_REG_RESET;
                else if (byte_done && have_addr_r && write_r && addr_r == 7'(gi))
                    regs_r[gi] <= sh_in;
            end
        end
    endgenerate

    logic [7:0] peek_r;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) peek_r <= 8'h00;
        else peek_r <= regs_r[PEEK_ADDR];
    end

    assign PEEK_DATA = peek_r;
    assign WR_STB = wstb_r;
    // MISO keeps its last bit while selected, released on deselect
    assign link.miso = miso_r;
    assign link.miso_oe = ~nsel_r;
endmodule // rsl_radio
`default_nettype wire

// file: rsl_link_checker.sv
// Link-level assertions for the radio serial link
`timescale 1ns/1ps
`default_nettype none
module rsl_link_checker (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic nsel
);
    // ----
    // Clock rises counted per selection; cleared while deselected
    // ----
    logic sck_q_r;
    logic [7:0] rises_r;
    logic [7:0] rises_nxt;
    assign rises_nxt = nsel ? 8'h00 : rises_r + {7'h00, sck & ~sck_q_r};
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sck_q_r <= 1'b0;
            rises_r <= 8'h00;
        end else begin
            sck_q_r <= sck;
            rises_r <= rises_nxt;
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);
    property p_sck_high; $rose(sck) |-> sck [*3] ##1 !sck; endproperty
    a_sck_high: assert property (p_sck_high) else $error("sck high time wrong");
    property p_sck_low; $fell(sck) |-> !sck [*3]; endproperty
    a_sck_low: assert property (p_sck_low) else $error("sck low time short");
    property p_mosi_stable; sck |-> $stable(mosi); endproperty
    a_mosi_stable: assert property (p_mosi_stable) else $error("mosi moved, sck high");
    property p_nsel_stable; sck |-> $stable(nsel); endproperty
    a_nsel_stable: assert property (p_nsel_stable) else $error("select moved, sck high");
    property p_idle_low; nsel && $past(nsel) |-> !sck; endproperty
    a_idle_low: assert property (p_idle_low) else $error("sck not idle low");
    // The radio sees select through its synchroniser, four cycles late
    property p_oe_off; nsel [*5] |-> !miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("miso driven, deselected");
    property p_oe_on; !nsel [*5] |-> miso_oe; endproperty
    a_oe_on: assert property (p_oe_on) else $error("miso not driven, selected");
    property p_bytes; $rose(nsel) |-> rises_r[2:0] == 3'h0 && rises_r != 8'h00; endproperty
    a_bytes: assert property (p_bytes) else $error("partial byte on link");
    c_sck: cover property ($rose(sck));
    c_burst: cover property ($rose(nsel) && rises_r == 8'h20);
    c_oe: cover property ($rose(miso_oe));
    c_miso: cover property (miso_oe && $rose(miso));
endmodule // rsl_link_checker
`default_nettype wire

// file: tb.sv
// Testbench joining the core-side master and the radio slave
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rsl_pkg::*;
    logic MCLK, NRST, WR_EN, RD_EN, REG_SEL, IRQ, BUSY, WR_STB;
    logic [7:0] WDATA, RDATA, PEEK_DATA, ctl_v, rx_v;
    logic [6:0] PEEK_ADDR;
    int fail_count = 0;
    int comparisons = 0;
    int stb_n = 0;
    logic [6:0] row_a [4] = '{7'h00, 7'h2a, 7'h7f, 7'h55};
    logic [7:0] row_d [4] = '{8'h5a, 8'hc3, 8'hff, 8'h81};
    rsl_if link();
    rsl_master rsl_master_inst (.MCLK(MCLK), .NRST(NRST), .WR_EN(WR_EN), .RD_EN(RD_EN),
        .REG_SEL(REG_SEL), .WDATA(WDATA), .RDATA(RDATA), .IRQ(IRQ), .BUSY(BUSY), .link(link));
    rsl_radio rsl_radio_inst (.MCLK(MCLK), .NRST(NRST), .PEEK_ADDR(PEEK_ADDR),
        .PEEK_DATA(PEEK_DATA), .WR_STB(WR_STB), .link(link));
    rsl_link_checker rsl_link_checker_inst (.MCLK(MCLK), .NRST(NRST), .sck(link.sck),
        .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .nsel(link.nsel));
    initial begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    always @(posedge MCLK) if (WR_STB === 1'b1) stb_n++;
    // ----
    // Bus tasks
    // ----
    task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
        comparisons++;
        if (s !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
            fail_count++;
        end
    endtask
    task automatic conclude();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic s, input logic [7:0] d);
        @(posedge MCLK);
        #1 WR_EN = 1'b1;
        REG_SEL = s;
        WDATA = d;
        @(posedge MCLK);
        #1 WR_EN = 1'b0;
    endtask
    task automatic rd(input logic s);
        @(posedge MCLK);
        #1 RD_EN = 1'b1;
        REG_SEL = s;
        @(posedge MCLK);
        #1 RD_EN = 1'b0;
    endtask
    // Bounded wait; a hang ends the run as a mismatch
    task automatic waitb(input logic v);
        for (int i = 0; i < 200 && BUSY !== v; i++) @(posedge MCLK) #1;
        if (BUSY !== v) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic sel(input logic [7:0] v);
        ctl_v = v;
        wr(REG_CTL, v);
    endtask
    // One byte, then read the received byte and clear the flags
    task automatic xfer(input logic [7:0] b);
        wr(REG_DATA, b);
        waitb(1'b1);
        waitb(1'b0);
        repeat (3) @(posedge MCLK);
        #1 check("irq", IRQ, 8'h01);
        rd(REG_DATA);
        rx_v = RDATA;
        wr(REG_CTL, ctl_v);
    endtask
    task automatic peek(input logic [6:0] a, input logic [7:0] e);
        @(posedge MCLK);
        #1 PEEK_ADDR = a;
        repeat (2) @(posedge MCLK);
        #1 check("peek", PEEK_DATA, e);
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        {NRST, WR_EN, RD_EN, REG_SEL, WDATA, PEEK_ADDR, ctl_v} = '0;
        repeat (5) @(posedge MCLK);
        #1 NRST = 1'b1;
        for (int i = 0; i < 4; i++) begin
            sel(8'h23);
            xfer({1'b1, row_a[i]});
            xfer(row_d[i]);
            sel(8'h33);
            peek(row_a[i], row_d[i]);
            sel(8'h23);
            xfer({1'b0, row_a[i]});
            xfer(~row_d[i]);
            sel(8'h33);
            check("read", rx_v, row_d[i]);
            peek(row_a[i], row_d[i]);
        end
        check("strobes", 8'(stb_n), 8'h04);
        sel(8'h23);
        xfer({1'b1, 7'h10});
        for (int j = 0; j < 3; j++) xfer(8'h11 << j);
        sel(8'h33);
        for (int j = 0; j < 3; j++) peek(7'h10 + 7'(j), 8'h11 << j);
        check("strobes", 8'(stb_n), 8'h07);
        sel(8'h23);
        xfer({1'b0, 7'h10});
        for (int j = 0; j < 3; j++) begin
            xfer(8'h00);
            check("burst read", rx_v, 8'h11 << j);
        end
        // Disabled engine keeps the byte until enabled
        sel(8'h22);
        wr(REG_DATA, 8'h05);
        repeat (10) @(posedge MCLK);
        check("busy off", BUSY, 8'h00);
        check("irq clear", IRQ, 8'h00);
        sel(8'h23);
        waitb(1'b1);
        waitb(1'b0);
        sel(8'h33);
        // Second write lands while the buffer is still full
        sel(8'h23);
        @(posedge MCLK);
        #1 {WR_EN, REG_SEL, WDATA} = {1'b1, REG_DATA, 8'h05};
        @(posedge MCLK);
        #1 WDATA = 8'h5a;
        @(posedge MCLK);
        #1 WR_EN = 1'b0;
        waitb(1'b1);
        waitb(1'b0);
        repeat (5) @(posedge MCLK);
        check("one byte", BUSY, 8'h00);
        rd(REG_CTL);
        check("flags", RDATA, 8'he3);
        sel(8'h33);
        // Reset in mid-transfer
        sel(8'h23);
        wr(REG_DATA, 8'h05);
        repeat (8) @(posedge MCLK);
        #1 NRST = 1'b0;
        #1 check("busy rst", BUSY, 8'h00);
        check("irq rst", IRQ, 8'h00);
        check("rdata rst", RDATA, 8'h00);
        @(posedge MCLK);
        #1 NRST = 1'b1;
        rd(REG_CTL);
        check("ctl rst", RDATA, CTL_RESET);
        peek(row_a[1], RADIO_REG_RESET);
        conclude();
    end
endmodule // tb
`default_nettype wire
